/* File: verilog/ofs_params.svh */
`ifndef OFS_PARAMS_SVH
`define OFS_PARAMS_SVH

// Register addresses on the serial control port (6-bit address field).
`define OFS_ADDR_OC_STATUS 6'h11
`define OFS_ADDR_OL_STATUS 6'h12
`define OFS_ADDR_CONFIG 6'h3f
`define OFS_ADDR_CTRL_THREE 6'h03

// Frame opcodes, top two bits of the first byte.
`define OFS_OP_WRITE 2'h0
`define OFS_OP_READ 2'h1
`define OFS_OP_READ_CLEAR 2'h2

// Frame layout: one command byte then one 16-bit data word.
`define OFS_FRAME_BITS 5'h18
`define OFS_CMD_BITS 5'h08

// Reset values.
`define OFS_STATUS_RESET 16'h0000
`define OFS_CONFIG_RESET 8'h00
`define OFS_CTRL_THREE_RESET 16'h0000

// Configuration register fields.
`define OFS_CFG_WARN_MASK_BIT 3
`define OFS_CFG_OUT1_HIGH_MASK_BIT 4
`define OFS_CFG_OUT1_LOW_MASK_BIT 5
`define OFS_CFG_EC_OUT7_MASK_BIT 6
`define OFS_CFG_WRITABLE 8'h78

// Control register three: duty cycle select for overcurrent recovery.
`define OFS_CR3_DUTY_BIT 14

// Status bit positions of the stages named by the mask bits.
`define OFS_STAGE_OUT1_LOW 0
`define OFS_STAGE_OUT1_HIGH 1
`define OFS_STAGE_OUTPUT7 11
`define OFS_STAGE_EC_VOLTAGE_LOW 14
`define OFS_STAGE_EC_FAST_DISCHARGE_LOW 15

// Timing.
`define OFS_CLK_PERIOD_NS 8
`define OFS_OL_FILTER_TIME_US 2000
`define OFS_OL_FILTER_CYC \
  ((`OFS_OL_FILTER_TIME_US * 1000 + `OFS_CLK_PERIOD_NS - 1) / `OFS_CLK_PERIOD_NS)
`define OFS_RECOV_OFF_LONG_NS 20000
`define OFS_RECOV_OFF_SHORT_NS 5000
`define OFS_RECOV_OFF_LONG_CYC (`OFS_RECOV_OFF_LONG_NS / `OFS_CLK_PERIOD_NS)
`define OFS_RECOV_OFF_SHORT_CYC (`OFS_RECOV_OFF_SHORT_NS / `OFS_CLK_PERIOD_NS)

// Widths of counters held in state structs.
`define OFS_RECOV_CNT_W 12
`define OFS_OL_CNT_W 18

`endif

/* File: verilog/ofs_pkg.sv */
`include "ofs_params.svh"

package ofs_pkg;

  typedef logic [`OFS_RECOV_CNT_W-1:0] ofs_recov_cnt_t;

  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] csn_s;
    logic [1:0] mosi_s;
    logic [1:0] tw_s;
    logic [1:0][15:0] oc_s;
    logic [4:0] bit_cnt;
    logic [23:0] in_sh;
    logic [15:0] out_sh;
    logic [15:0] shown;
    logic [1:0] op;
    logic [5:0] addr;
    logic miso;
    logic [15:0] oc;
    logic [15:0] ol;
    logic [7:0] cfg;
    logic [15:0] cr3;
    logic [15:0][`OFS_RECOV_CNT_W-1:0] recov;
    logic [15:0] drv;
    logic global_warning_open_load_flag;
    logic err;
  } ofs_state_t;

  typedef struct packed {
    logic [1:0] uc_s;
    logic [`OFS_OL_CNT_W-1:0] cnt;
    logic hit;
  } ofs_filt_state_t;

endpackage : ofs_pkg

/* File: verilog/ofs_ol_filter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ofs_params.svh"

// Undercurrent filter for one stage: flags open load after a continuous low-current run.
module ofs_ol_filter
  import ofs_pkg::*;
#(
  parameter int unsigned FILTER_CYC = `OFS_OL_FILTER_CYC
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Stage condition.
  input wire logic stage_active_in,
  input wire logic undercurrent_in,
  // Result.
  output logic open_load_out
);

  localparam logic [`OFS_OL_CNT_W-1:0] LIMIT = `OFS_OL_CNT_W'(FILTER_CYC - 1);

  ofs_filt_state_t s_r;
  ofs_filt_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.uc_s = {s_r.uc_s[0], undercurrent_in};
    s_nxt.hit = 1'b0;
    // Any break in the low-current run restarts the count.
    if (!(stage_active_in && s_r.uc_s[1])) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt >= LIMIT) begin
      s_nxt.hit = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign open_load_out = s_r.hit;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_ol_filter;
    (stage_active_in && s_r.uc_s[1] && s_r.cnt == LIMIT) |=> open_load_out;
  endproperty
  a_ol_filter: assert property (p_ol_filter) else $error("Open load not flagged at filter end.");

  property p_ol_no_early;
    open_load_out |-> $past(s_r.cnt) == LIMIT;
  endproperty
  a_ol_no_early: assert property (p_ol_no_early) else $error("Open load flagged too early.");

endmodule : ofs_ol_filter

`default_nettype wire

/* File: verilog/ofs_status_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ofs_params.svh"

// Behaviour
// - The overcurrent status register sits at 11h, resets to zero, one bit per stage.
// - The open-load status register sits at 12h, resets to zero, same stage order.
// - A detected overcurrent sets the stage's status bit and switches its driver off.
// - With recovery enabled the driver comes back on by itself after an off delay.
// - An active stage whose current stays low for 2 ms gets its open-load bit set.
// - Configuration bits 4 and 5 mask open load of output 1 high side and low side.
// - Configuration bit 6 masks open load of the two EC low-side stages and output 7.
// - A masked open load does not feed the combined warning/open-load flag.
// - Bit 14 of control register three selects the recovery duty cycle.
// - With the global warning mask set, warning and open load do not raise the error flag.
module ofs_status_regs
  import ofs_pkg::*;
#(
  parameter int unsigned OL_FILTER_CYC = `OFS_OL_FILTER_CYC
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Serial control port.
  input wire logic spi_clock_in,
  input wire logic spi_select_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  // Stage sensing and control.
  input wire logic [15:0] overcurrent_detect_in,
  input wire logic [15:0] undercurrent_in,
  input wire logic [15:0] stage_on_in,
  input wire logic [15:0] recovery_enable_in,
  input wire logic temp_warning_in,
  output logic [15:0] driver_enable_out,
  // Global status.
  output logic global_warning_open_load_flag_out,
  output logic global_error_flag_out
);

  localparam logic [`OFS_RECOV_CNT_W-1:0] OFF_LONG = `OFS_RECOV_CNT_W'(`OFS_RECOV_OFF_LONG_CYC);
  localparam logic [`OFS_RECOV_CNT_W-1:0] OFF_SHORT = `OFS_RECOV_CNT_W'(`OFS_RECOV_OFF_SHORT_CYC);

  function automatic logic [15:0] ofs_ol_mask(input logic [7:0] cfg);
    logic [15:0] m;
    m = '0;
    m[`OFS_STAGE_OUT1_HIGH] = cfg[`OFS_CFG_OUT1_HIGH_MASK_BIT];
    m[`OFS_STAGE_OUT1_LOW] = cfg[`OFS_CFG_OUT1_LOW_MASK_BIT];
    m[`OFS_STAGE_OUTPUT7] = cfg[`OFS_CFG_EC_OUT7_MASK_BIT];
    m[`OFS_STAGE_EC_VOLTAGE_LOW] = cfg[`OFS_CFG_EC_OUT7_MASK_BIT];
    m[`OFS_STAGE_EC_FAST_DISCHARGE_LOW] = cfg[`OFS_CFG_EC_OUT7_MASK_BIT];
    return m;
  endfunction : ofs_ol_mask

  function automatic logic [15:0] ofs_read(input ofs_state_t st, input logic [5:0] addr);
    logic [15:0] v;
    v = '0;
    case (addr)
      `OFS_ADDR_OC_STATUS: v = st.oc;
      `OFS_ADDR_OL_STATUS: v = st.ol;
      `OFS_ADDR_CONFIG: v = {8'h00, st.cfg};
      `OFS_ADDR_CTRL_THREE: v = st.cr3;
      default: v = '0;
    endcase
    return v;
  endfunction : ofs_read

  ofs_state_t s_r;
  ofs_state_t s_nxt;
  logic [15:0] ol_hit;
  logic [15:0] oc_det;
  logic sck_rise;
  logic frame_end;
  logic [7:0] cmd_byte;
  logic [15:0] clr_oc;
  logic [15:0] clr_ol;
  logic [`OFS_RECOV_CNT_W-1:0] off_cyc;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_filt
      ofs_ol_filter #(
        .FILTER_CYC(OL_FILTER_CYC)
      ) u_filt (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .stage_active_in(stage_on_in[g] & s_r.drv[g]),
        .undercurrent_in(undercurrent_in[g]),
        .open_load_out(ol_hit[g])
      );
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    sck_rise = s_r.sck_s[1] & ~s_r.sck_s[2];
    frame_end = s_r.csn_s[1] & ~s_r.csn_s[2] & (s_r.bit_cnt == `OFS_FRAME_BITS);
    cmd_byte = {s_r.in_sh[6:0], s_r.mosi_s[1]};
    // Only an overcurrent seen while the driver is on counts as a fresh event.
    oc_det = s_r.oc_s[1] & s_r.drv;
    off_cyc = s_r.cr3[`OFS_CR3_DUTY_BIT] ? OFF_SHORT : OFF_LONG;
    // Clearing only the bits actually shifted out keeps events that arrive during the frame.
    clr_oc = (frame_end && s_r.op == `OFS_OP_READ_CLEAR &&
              s_r.addr == `OFS_ADDR_OC_STATUS) ? s_r.shown : '0;
    clr_ol = (frame_end && s_r.op == `OFS_OP_READ_CLEAR &&
              s_r.addr == `OFS_ADDR_OL_STATUS) ? s_r.shown : '0;

    s_nxt.sck_s = {s_r.sck_s[1:0], spi_clock_in};
    s_nxt.csn_s = {s_r.csn_s[1:0], spi_select_n_in};
    s_nxt.mosi_s = {s_r.mosi_s[0], spi_mosi_in};
    s_nxt.tw_s = {s_r.tw_s[0], temp_warning_in};
    s_nxt.oc_s = {s_r.oc_s[0], overcurrent_detect_in};
    s_nxt.miso = s_r.out_sh[15];

    if (s_r.csn_s[1]) begin
      s_nxt.bit_cnt = '0;
    end else if (sck_rise && s_r.bit_cnt < `OFS_FRAME_BITS) begin
      s_nxt.in_sh = {s_r.in_sh[22:0], s_r.mosi_s[1]};
      s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
      if (s_r.bit_cnt >= `OFS_CMD_BITS) begin
        s_nxt.out_sh = {s_r.out_sh[14:0], 1'b0};
      end
      if (s_r.bit_cnt == `OFS_CMD_BITS - 5'h01) begin
        s_nxt.op = cmd_byte[7:6];
        s_nxt.addr = cmd_byte[5:0];
        s_nxt.out_sh = ofs_read(s_r, cmd_byte[5:0]);
        s_nxt.shown = ofs_read(s_r, cmd_byte[5:0]);
      end
    end else if (sck_rise && s_r.bit_cnt == `OFS_FRAME_BITS) begin
      // An edge past the last bit spoils the frame, so it ends with no write or clear.
      s_nxt.bit_cnt = `OFS_FRAME_BITS + 5'h01;
    end

    if (frame_end && s_r.op == `OFS_OP_WRITE) begin
      if (s_r.addr == `OFS_ADDR_CONFIG) begin
        s_nxt.cfg = s_r.in_sh[7:0] & `OFS_CFG_WRITABLE;
      end else if (s_r.addr == `OFS_ADDR_CTRL_THREE) begin
        s_nxt.cr3 = s_r.in_sh[15:0];
      end
    end

    // Set beats clear: new events are merged after the clear.
    s_nxt.oc = (s_r.oc & ~clr_oc) | oc_det;
    s_nxt.ol = (s_r.ol & ~clr_ol) | ol_hit;

    for (int i = 0; i < 16; i++) begin
      if (s_r.recov[i] != '0) begin
        s_nxt.recov[i] = s_r.recov[i] - 1'b1;
      end
      if (oc_det[i] && recovery_enable_in[i]) begin
        s_nxt.recov[i] = off_cyc;
      end
      // Without recovery the sticky bit alone holds the driver off.
      s_nxt.drv[i] = (s_nxt.recov[i] == '0) &&
                     !(s_nxt.oc[i] && !recovery_enable_in[i]);
    end

    s_nxt.global_warning_open_load_flag = s_r.tw_s[1] | (|(s_r.ol & ~ofs_ol_mask(s_r.cfg)));
    // Only the faults kept here feed the error flag; other sources merge outside.
    s_nxt.err = (|s_r.oc) | (s_r.global_warning_open_load_flag & ~s_r.cfg[`OFS_CFG_WARN_MASK_BIT]);
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= '{sck_s: '0, csn_s: 3'h7, mosi_s: '0, tw_s: '0, oc_s: '0, bit_cnt: '0,
               in_sh: '0, out_sh: '0, shown: '0, op: '0, addr: '0, miso: 1'b0,
               oc: `OFS_STATUS_RESET, ol: `OFS_STATUS_RESET, cfg: `OFS_CONFIG_RESET,
               cr3: `OFS_CTRL_THREE_RESET, recov: '0, drv: 16'hffff, global_warning_open_load_flag: 1'b0,
               err: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign spi_miso_out = s_r.miso;
  assign spi_miso_oe_out = ~s_r.csn_s[1];
  assign driver_enable_out = s_r.drv;
  assign global_warning_open_load_flag_out = s_r.global_warning_open_load_flag;
  assign global_error_flag_out = s_r.err;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  logic load_ev;
  assign load_ev = !s_r.csn_s[1] && sck_rise && s_r.bit_cnt == `OFS_CMD_BITS - 5'h01;

  property p_oc_read;
    (load_ev && cmd_byte[5:0] == `OFS_ADDR_OC_STATUS) |=> s_r.out_sh == $past(s_r.oc);
  endproperty
  a_oc_read: assert property (p_oc_read) else $error("Overcurrent word not loaded.");

  property p_ol_read;
    (load_ev && cmd_byte[5:0] == `OFS_ADDR_OL_STATUS) |=> s_r.out_sh == $past(s_r.ol);
  endproperty
  a_ol_read: assert property (p_ol_read) else $error("Open-load word not loaded.");

  property p_oc_set_off;
    oc_det != '0 |=> ((s_r.oc & $past(oc_det)) == $past(oc_det)) &&
                     ((s_r.drv & $past(oc_det)) == '0);
  endproperty
  a_oc_set_off: assert property (p_oc_set_off) else $error("Overcurrent not latched or driver on.");

  property p_recov_load;
    (oc_det[0] && recovery_enable_in[0]) |=> s_r.recov[0] == $past(off_cyc) && !s_r.drv[0];
  endproperty
  a_recov_load: assert property (p_recov_load) else $error("Recovery delay not started.");

  property p_duty_sel;
    (oc_det[0] && recovery_enable_in[0] && s_r.cr3[`OFS_CR3_DUTY_BIT])
      |=> s_r.recov[0] == OFF_SHORT;
  endproperty
  a_duty_sel: assert property (p_duty_sel) else $error("Duty select ignored.");

  property p_ol_latch;
    ol_hit != '0 |=> (s_r.ol & $past(ol_hit)) == $past(ol_hit);
  endproperty
  a_ol_latch: assert property (p_ol_latch) else $error("Open-load bit not set.");

  property p_sticky;
    ##1 ((($past(s_r.oc) & ~$past(clr_oc)) & ~s_r.oc) == '0) &&
        ((($past(s_r.ol) & ~$past(clr_ol)) & ~s_r.ol) == '0);
  endproperty
  a_sticky: assert property (p_sticky) else $error("Status bit lost without clear.");

  property p_out1_mask;
    (s_r.cfg[`OFS_CFG_OUT1_HIGH_MASK_BIT] && s_r.cfg[`OFS_CFG_OUT1_LOW_MASK_BIT] &&
     s_r.ol[15:2] == '0 && !s_r.tw_s[1]) |=> !s_r.global_warning_open_load_flag;
  endproperty
  a_out1_mask: assert property (p_out1_mask) else $error("Output 1 mask leaked.");

  property p_ec_mask;
    (s_r.cfg[`OFS_CFG_EC_OUT7_MASK_BIT] && (s_r.ol & 16'h37ff) == '0 && !s_r.tw_s[1])
      |=> !s_r.global_warning_open_load_flag;
  endproperty
  a_ec_mask: assert property (p_ec_mask) else $error("EC/output 7 mask leaked.");

  property p_flag_unmasked;
    (s_r.ol[2] || s_r.tw_s[1]) |=> s_r.global_warning_open_load_flag;
  endproperty
  a_flag_unmasked: assert property (p_flag_unmasked) else $error("Warning flag missed.");

  property p_warn_mask;
    (s_r.cfg[`OFS_CFG_WARN_MASK_BIT] && s_r.oc == '0) |=> !s_r.err;
  endproperty
  a_warn_mask: assert property (p_warn_mask) else $error("Masked warning raised error.");

  c_oc_event: cover property (oc_det != '0);
  c_rd_clear: cover property (frame_end && s_r.op == `OFS_OP_READ_CLEAR && s_r.shown != '0);
  c_ol_event: cover property (ol_hit != '0);
  c_recover: cover property (s_r.recov[0] == 12'h001 ##1 s_r.drv[0]);

endmodule : ofs_status_regs

`default_nettype wire

/* File: verification/ofs_spi_master.sv */
`timescale 1ns/1ns
`default_nettype none

// Controller model: clock idles low, 24-bit frames, read bits taken on rising edges 9 to 24.
module ofs_spi_master (
  // Clock.
  input wire logic sys_clk_in,
  // Serial port.
  output logic spi_clock_out,
  output logic spi_select_n_out,
  output logic spi_mosi_out,
  input wire logic spi_miso_in,
  // Read results.
  output logic [15:0] word_out,
  output logic word_valid_out
);
  initial begin
    spi_clock_out = 1'b0;
    spi_select_n_out = 1'b1;
    spi_mosi_out = 1'b0;
    word_out = 16'h0000;
    word_valid_out = 1'b0;
  end

  task automatic frame(input logic [1:0] op, input logic [5:0] addr, input logic [15:0] wdata);
    logic [23:0] sh;
    sh = {op, addr, wdata};
    spi_select_n_out = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    for (int k = 23; k >= 0; k--) begin
      spi_mosi_out = sh[k];
      repeat (10) @(negedge sys_clk_in);
      spi_clock_out = 1'b1;
      if (k < 16) word_out[k] = spi_miso_in;
      repeat (10) @(negedge sys_clk_in);
      spi_clock_out = 1'b0;
    end
    repeat (2) @(negedge sys_clk_in);
    spi_select_n_out = 1'b1;
    // A released data line must not keep showing the last bit.
    spi_mosi_out = ~spi_mosi_out;
    repeat (5) @(negedge sys_clk_in);
    word_valid_out = (op != 2'h0);
    @(negedge sys_clk_in);
    word_valid_out = 1'b0;
  endtask : frame
endmodule : ofs_spi_master

`default_nettype wire

/* File: verification/ofs_status_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ofs_params.svh"

module ofs_status_regs_tb;
  localparam int unsigned FILT = 20;
  localparam logic [1:0] RD = `OFS_OP_READ;
  localparam logic [1:0] RC = `OFS_OP_READ_CLEAR;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic spi_clock, spi_select_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [15:0] oc_det = 16'h0000, uc = 16'h0000, stage_on = 16'h0000, recov_en = 16'h0000;
  logic temp_warn = 1'b0;
  logic [15:0] drv_en, rd_word, ol, masked;
  logic warn_flag, err_flag, rd_valid, wflag, in_win;
  logic [7:0] cfg;
  logic [15:0] exp_q[$];
  logic [15:0] duty[2] = '{16'h0000, 16'h4000};
  int off[2] = '{`OFS_RECOV_OFF_LONG_CYC, `OFS_RECOV_OFF_SHORT_CYC};
  logic [7:0] cfg_t[6] = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h70, 8'h00};
  logic [15:0] ol_t[5] = '{16'h0001, 16'h0002, 16'h0001, 16'hc800, 16'hc803};
  int fails = 0, n_compared = 0, cycles = 0, sel_lo = 0, b, n;
  logic [31:0] seed_val;

  always #4 sys_clk_in = ~sys_clk_in;

  ofs_status_regs #(.OL_FILTER_CYC(FILT)) ofs_status_regs_i (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .spi_clock_in(spi_clock), .spi_select_n_in(spi_select_n), .spi_mosi_in(spi_mosi),
    .spi_miso_out(spi_miso), .spi_miso_oe_out(spi_miso_oe),
    .overcurrent_detect_in(oc_det), .undercurrent_in(uc), .stage_on_in(stage_on),
    .recovery_enable_in(recov_en), .temp_warning_in(temp_warn), .driver_enable_out(drv_en),
    .global_warning_open_load_flag_out(warn_flag), .global_error_flag_out(err_flag)
  );

  ofs_spi_master ofs_spi_master_i (
    .sys_clk_in(sys_clk_in), .spi_clock_out(spi_clock), .spi_select_n_out(spi_select_n),
    .spi_mosi_out(spi_mosi), .spi_miso_in(spi_miso), .word_out(rd_word),
    .word_valid_out(rd_valid)
  );

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic check_read(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t read word %h expected %h", $time, got, exp);
    end
  endtask : check_read

  task automatic check_pin(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: %h expected %h", $time, what, got, exp);
    end
  endtask : check_pin

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_in);
  endtask : cyc

  task automatic rd(input logic [1:0] op, input logic [5:0] addr, input logic [15:0] exp);
    exp_q.push_back(exp);
    ofs_spi_master_i.frame(op, addr, 16'h0000);
  endtask : rd

  task automatic wr(input logic [5:0] addr, input logic [15:0] data);
    ofs_spi_master_i.frame(`OFS_OP_WRITE, addr, data);
  endtask : wr

  // Results arrive from the controller model; each is matched against the oldest note.
  always @(posedge sys_clk_in) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[FAIL] %0t read word with nothing expected", $time);
      end else begin
        check_read(rd_word, exp_q.pop_front());
      end
    end
  end

  // Well inside a frame the block must be driving its data line.
  always @(posedge sys_clk_in) begin
    sel_lo <= spi_select_n ? 0 : sel_lo + 1;
    if (sel_lo == 10) begin
      check_pin({15'h0000, spi_miso_oe}, 16'h0001, "data drive in frame");
    end
  end

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      $display("[FAIL] %0t run did not finish in time", $time);
      end_sim();
    end
  end

  initial begin
    seed_val = $urandom(32'h493a33b7);
    cyc(2);
    arst_n_in = 1'b1;
    cyc(4);
    check_pin({13'h0000, spi_miso_oe, warn_flag, err_flag}, 16'h0000, "after reset");
    rd(RD, `OFS_ADDR_OC_STATUS, `OFS_STATUS_RESET);
    rd(RD, `OFS_ADDR_OL_STATUS, `OFS_STATUS_RESET);
    rd(RD, 6'h20, 16'h0000);
    check_pin(drv_en, 16'hffff, "drivers after reset");
    $display("test reset done");

    b = $urandom_range(15, 0);
    oc_det[b] = 1'b1;
    cyc(5);
    check_pin(drv_en, ~(16'h0001 << b), "driver off on overcurrent");
    check_pin({15'h0000, err_flag}, 16'h0001, "error flag");
    oc_det[b] = 1'b0;
    cyc(3000);
    check_pin(drv_en, ~(16'h0001 << b), "driver held off");
    rd(RD, `OFS_ADDR_OC_STATUS, 16'h0001 << b);
    // Opcode 3 reads without clearing and a write to a status word is ignored.
    rd(2'h3, `OFS_ADDR_OC_STATUS, 16'h0001 << b);
    wr(`OFS_ADDR_OC_STATUS, 16'hffff);
    rd(RC, `OFS_ADDR_OC_STATUS, 16'h0001 << b);
    cyc(4);
    check_pin(drv_en, 16'hffff, "driver back after clear");
    rd(RD, `OFS_ADDR_OC_STATUS, 16'h0000);
    $display("test latched overcurrent done");

    for (int i = 0; i < 2; i++) begin
      wr(`OFS_ADDR_CTRL_THREE, duty[i]);
      rd(RD, `OFS_ADDR_CTRL_THREE, duty[i]);
      b = $urandom_range(15, 0);
      recov_en = 16'h0001 << b;
      oc_det[b] = 1'b1;
      cyc(4);
      oc_det[b] = 1'b0;
      n = 0;
      while (drv_en[b] !== 1'b1 && n < 4000) begin
        cyc(1);
        n++;
      end
      in_win = (n + 4 >= off[i]) && (n + 4 <= off[i] + 6);
      check_pin({15'h0000, in_win}, 16'h0001, "recovery off time");
      rd(RC, `OFS_ADDR_OC_STATUS, 16'h0001 << b);
      recov_en = 16'h0000;
    end
    $display("test automatic recovery done");

    for (int t = 0; t < 6; t++) begin
      cfg = cfg_t[t];
      ol = (t < 5) ? ol_t[t] : (16'($urandom) & 16'hffdf);
      wr(`OFS_ADDR_CONFIG, {8'h00, cfg});
      rd(RD, `OFS_ADDR_CONFIG, {8'h00, cfg});
      temp_warn = (t == 0);
      stage_on = 16'hffdf;
      uc = ol | 16'h0020;
      // A short switch-on, half again the filter time, probes the load.
      cyc(FILT + FILT / 2);
      uc = 16'h0000;
      stage_on = 16'h0000;
      cyc(6);
      masked = ol & ~{cfg[6], cfg[6], 2'b00, cfg[6], 9'h000, cfg[4], cfg[5]};
      wflag = (|masked) | temp_warn;
      check_pin({15'h0000, warn_flag}, {15'h0000, wflag}, "warning flag");
      check_pin({15'h0000, err_flag}, {15'h0000, wflag & ~cfg[3]}, "error flag");
      rd(RD, `OFS_ADDR_OL_STATUS, ol);
      rd(RC, `OFS_ADDR_OL_STATUS, ol);
      temp_warn = 1'b0;
    end
    rd(RD, `OFS_ADDR_OL_STATUS, 16'h0000);
    $display("test open load and masks done");
    cyc(4);
    check_pin({15'h0000, spi_miso_oe}, 16'h0000, "data drive after frame");
    end_sim();
  end
endmodule : ofs_status_regs_tb

`default_nettype wire
